/* logic/port0_defs.svh */
// port 0 constants: offsets, field layout, reset values, and functional notes
//
// Functional notes
// - direction bit 1 makes the pin a port output driving the latch value.
// - direction bit 0 makes the pin a port input; latch is not driven.
// - writing the data register updates the latch; output pins follow it.
// - writing the data register on input pins updates the latch only.
// - normal data read returns the latch for port output pins.
// - input pins read the pin level; read-modify-write reads return the latch.
// - an enabled peripheral output overrides the port output path.
// - peripheral-driven pins read the pin level; read-modify-write reads the latch.
// - peripheral-input pins still read the pin level; read-modify-write the latch.
// - bit n of each per-pin register controls pin n, bits 0 to 7; segment select has bits 1 to 7 only.
// - analog-disable 0 enables analog and blocks digital input; 1 enables digital.
// - reset clears direction and analog-disable bits: inputs, digital input blocked.
// - float bit 1 in standby: all pins high impedance, inputs forced low.
// - in floated standby, pins with interrupt input enabled keep their input open.
// - float bit 0 in standby: pin state and output levels are held.
// - pin level feeds the interrupt circuit except on floated pins without interrupt enable; software disables unused ones.
`ifndef PORT0_DEFS_SVH
`define PORT0_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_LATCH 8'h00
`define OFS_DIRECTION 8'h04
`define OFS_ANALOG_DISABLE 8'h08
`define OFS_CONTROL 8'h0C
`define OFS_SEGMENT_SELECT 8'h10
`define OFS_RMW_VIEW 8'h14

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CTRL_LCD_PORT_INPUT_CONTROL_BIT 0
`define CTRL_SPL_BIT 1
`define SEG_MASK 8'hFE
`define RST_LATCH 8'h00
`define RST_DIRECTION 8'h00
`define RST_ANALOG_DISABLE 8'h00
`define RST_SEGMENT_SELECT 8'h00

`endif

/* logic/port0_pkg.sv */
// port 0 types shared by the top and the pin cell
package port0_pkg;

  // ----------------------------------------------------------------
  // per-pin control bundle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic latch;
    logic direction;
    logic analog_disable;
    logic lcd_active;
    logic periph_oe;
    logic periph_o;
    logic lcd_o;
    logic ext_irq_en;
    logic floated;
  } pin_ctrl_type;

  // ----------------------------------------------------------------
  // software visible register set
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] direction;
    logic [7:0] analog_disable;
    logic [7:0] segment_select;
    logic lcd_port_input_control;
    logic standby_pin_float;
  } regs_type;

endpackage : port0_pkg

/* logic/port0_pin_cell.sv */
// one port 0 pin: input synchroniser, output multiplexer and input gating
`timescale 1ns/100ps
module port0_pin_cell (
  input wire logic hclk, // system clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire port0_pkg::pin_ctrl_type ctrl, // control for this pin
  input wire logic pin_i, // pad input level
  output logic pin_o, // pad output level
  output logic pin_oe_n, // pad output enable, low drives
  output logic dig_in, // gated digital input level
  output logic irq_level // level toward the interrupt circuit
);

  logic sync1_q;
  logic sync2_q;
  logic out_d;
  logic out_q;
  logic oe_n_d;
  logic oe_n_q;
  logic din_d;
  logic din_q;
  logic irq_d;
  logic irq_q;

  // next pad drive and gated input levels
  always_comb begin
    out_d = ctrl.latch;
    oe_n_d = 1'b1;
    if (ctrl.floated) begin
      out_d = 1'b0;
      oe_n_d = 1'b1;
    end else if (ctrl.lcd_active) begin
      out_d = ctrl.lcd_o;
      oe_n_d = 1'b0;
    end else if (ctrl.periph_oe) begin
      out_d = ctrl.periph_o;
      oe_n_d = 1'b0;
    end else begin
      out_d = ctrl.latch;
      oe_n_d = ~ctrl.direction;
    end
    // digital input needs the analog path disabled; standby float blocks it unless interrupt input is enabled
    din_d = sync2_q & ctrl.analog_disable & (~ctrl.floated | ctrl.ext_irq_en);
    // interrupt feed is always open except while floated and not enabled
    irq_d = sync2_q & (~ctrl.floated | ctrl.ext_irq_en);
  end

  // synchroniser and output registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      out_q <= 1'b0;
      oe_n_q <= 1'b1;
      din_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      din_q <= din_d;
      irq_q <= irq_d;
    end
  end

  assign pin_o = out_q;
  assign pin_oe_n = oe_n_q;
  assign dig_in = din_q;
  assign irq_level = irq_q;

endmodule : port0_pin_cell

/* logic/port0_general_io.sv */
// port 0 general-purpose i/o: ahb-lite register slave and eight pin cells
`timescale 1ns/100ps
`include "port0_defs.svh"
module port0_general_io (
  input wire logic hclk, // system clock, 200 MHz
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic hreadyout, // slave ready
  output logic hresp, // response, always okay
  output logic [31:0] hrdata, // read data
  input wire logic standby_req, // stop or watch mode active
  input wire logic [7:0] periph_oe, // peripheral output enables
  input wire logic [7:0] periph_o, // peripheral output levels
  input wire logic [7:0] lcd_seg_o, // lcd segment output levels
  input wire logic [7:0] ext_irq_en, // external interrupt enables
  input wire logic [7:0] pin_i, // pad input levels
  output logic [7:0] pin_o, // pad output levels
  output logic [7:0] pin_oe_n, // pad output enables, low drives
  output logic [7:0] periph_in, // gated digital input to peripherals
  output logic [7:0] ext_irq_level, // pin levels to interrupt circuit
  output logic [7:0] analog_input_en // analog input path enables
);

  // ----------------------------------------------------------------
  // bus and register state
  // ----------------------------------------------------------------
  port0_pkg::regs_type regs_q;
  port0_pkg::regs_type regs_d;
  logic ap_valid_q;
  logic ap_valid_d;
  logic ap_write_q;
  logic ap_write_d;
  logic [7:0] ap_addr_q;
  logic [7:0] ap_addr_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic take;
  logic floated;
  logic [7:0] lcd_act;
  logic [7:0] port_mode;
  logic [7:0] level;
  logic [7:0] normal_view;
  logic [7:0] ctrl_next_view;

  // address phase is taken when the slave is selected for a real transfer
  assign take = hsel & htrans[1] & hready;

  // standby float state for all pins
  assign floated = standby_req & regs_q.standby_pin_float;

  // a segment pin drives lcd once both select and input control are set
  assign lcd_act = regs_q.segment_select & {8{regs_q.lcd_port_input_control}};

  // pins that behave as plain port pins, neither lcd nor peripheral output
  assign port_mode = ~lcd_act & ~periph_oe;

  // ----------------------------------------------------------------
  // register next state
  // ----------------------------------------------------------------
  always_comb begin
    regs_d = regs_q;
    ap_valid_d = take;
    ap_write_d = hwrite;
    ap_addr_d = {haddr[7:2], 2'b00};
    if (ap_valid_q && ap_write_q) begin
      unique case (ap_addr_q)
        `OFS_LATCH, `OFS_RMW_VIEW: begin
          regs_d.latch = hwdata[7:0];
        end
        `OFS_DIRECTION: begin
          regs_d.direction = hwdata[7:0];
        end
        `OFS_ANALOG_DISABLE: begin
          regs_d.analog_disable = hwdata[7:0];
        end
        `OFS_CONTROL: begin
          regs_d.lcd_port_input_control = hwdata[`CTRL_LCD_PORT_INPUT_CONTROL_BIT];
          regs_d.standby_pin_float = hwdata[`CTRL_SPL_BIT];
        end
        `OFS_SEGMENT_SELECT: begin
          regs_d.segment_select = hwdata[7:0] & `SEG_MASK;
        end
        default: begin
          regs_d = regs_q; // unmapped writes are dropped
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read data: built at the address phase from the next register values
  // ----------------------------------------------------------------
  assign ctrl_next_view = {6'h00, regs_d.standby_pin_float, regs_d.lcd_port_input_control};

  // port output pins show the latch, all others show the pin level
  assign normal_view = (regs_d.latch & regs_d.direction & port_mode)
    | (level & ~(regs_d.direction & port_mode));

  always_comb begin
    rdata_d = rdata_q;
    if (take && !hwrite) begin
      unique case ({haddr[7:2], 2'b00})
        `OFS_LATCH: rdata_d = {24'h000000, normal_view};
        `OFS_RMW_VIEW: rdata_d = {24'h000000, regs_d.latch};
        `OFS_DIRECTION: rdata_d = {24'h000000, regs_d.direction};
        `OFS_ANALOG_DISABLE: rdata_d = {24'h000000, regs_d.analog_disable};
        `OFS_CONTROL: rdata_d = {24'h000000, ctrl_next_view};
        `OFS_SEGMENT_SELECT: rdata_d = {24'h000000, regs_d.segment_select};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // register all bus and control state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      regs_q.latch <= `RST_LATCH;
      regs_q.direction <= `RST_DIRECTION;
      regs_q.analog_disable <= `RST_ANALOG_DISABLE;
      regs_q.segment_select <= `RST_SEGMENT_SELECT;
      regs_q.lcd_port_input_control <= 1'b0;
      regs_q.standby_pin_float <= 1'b0;
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      regs_q <= regs_d;
      ap_valid_q <= ap_valid_d;
      ap_write_q <= ap_write_d;
      ap_addr_q <= ap_addr_d;
      rdata_q <= rdata_d;
    end
  end

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign analog_input_en = ~regs_q.analog_disable;

  // ----------------------------------------------------------------
  // pin cells, one per bit
  // ----------------------------------------------------------------
  genvar n;
  generate
    for (n = 0; n < 8; n = n + 1) begin : g_pin
      port0_pkg::pin_ctrl_type ctrl;
      // collect this pin's control bits
      always_comb begin
        ctrl.latch = regs_q.latch[n];
        ctrl.direction = regs_q.direction[n];
        ctrl.analog_disable = regs_q.analog_disable[n];
        ctrl.lcd_active = lcd_act[n];
        ctrl.periph_oe = periph_oe[n];
        ctrl.periph_o = periph_o[n];
        ctrl.lcd_o = lcd_seg_o[n];
        ctrl.ext_irq_en = ext_irq_en[n];
        ctrl.floated = floated;
      end
      port0_pin_cell u_cell (
        .hclk(hclk),
        .hresetn(hresetn),
        .ctrl(ctrl),
        .pin_i(pin_i[n]),
        .pin_o(pin_o[n]),
        .pin_oe_n(pin_oe_n[n]),
        .dig_in(level[n]),
        .irq_level(ext_irq_level[n])
      );
    end
  endgenerate

  assign periph_in = level;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic seen_q;
  logic [7:0] out_mask;
  logic [7:0] in_mask;
  logic latch_wr;
  logic latch_rd;
  logic rmw_rd;

  // marks the first cycle after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  // helper masks of plain port output and input pins
  assign out_mask = regs_q.direction & port_mode & ~{8{floated}};
  assign in_mask = ~regs_q.direction & port_mode & ~{8{floated}};
  assign latch_wr = ap_valid_q & ap_write_q & (ap_addr_q == `OFS_LATCH);
  assign latch_rd = take & ~hwrite & ({haddr[7:2], 2'b00} == `OFS_LATCH);
  assign rmw_rd = take & ~hwrite & ({haddr[7:2], 2'b00} == `OFS_RMW_VIEW);

  a_port_output_drive: assert property (
    1'b1 |=> (((pin_oe_n & $past(out_mask)) == 8'h00)
      && (((pin_o ^ $past(regs_q.latch)) & $past(out_mask)) == 8'h00)))
    else $error("port output pin not driving latch");

  a_port_input_undriven: assert property (
    1'b1 |=> ((~pin_oe_n & $past(in_mask)) == 8'h00))
    else $error("port input pin driven");

  a_latch_write_pin: assert property (
    latch_wr |=> (regs_q.latch == $past(hwdata[7:0]))
      ##1 (((pin_o ^ $past(regs_q.latch)) & $past(out_mask)) == 8'h00))
    else $error("latch write not seen on output pins");

  a_normal_read_view: assert property (
    latch_rd |=> (hrdata[7:0] == $past(normal_view)) && (hrdata[31:8] == 24'h000000))
    else $error("normal read returned wrong view");

  a_rmw_read_latch: assert property (
    rmw_rd |=> hrdata[7:0] == $past(regs_d.latch))
    else $error("read-modify-write read did not return latch");

  a_periph_override: assert property (
    1'b1 |=> (((pin_o ^ $past(periph_o)) & $past(periph_oe & ~lcd_act & ~{8{floated}}))
      == 8'h00))
    else $error("peripheral output not on pin");

  a_reset_clears: assert property (
    !seen_q |-> (regs_q.direction == 8'h00) && (regs_q.analog_disable == 8'h00)
      && (pin_oe_n == 8'hFF))
    else $error("reset state not cleared");

  a_float_hiz: assert property (
    floated |=> pin_oe_n == 8'hFF)
    else $error("floated standby pin still driven");

  a_float_input_block: assert property (
    floated [*2] |=> ((level | ext_irq_level) & ~$past(ext_irq_en) & ~$past(ext_irq_en, 2))
      == 8'h00)
    else $error("floated input not blocked");

  a_lcd_priority: assert property (
    1'b1 |=> (((pin_o ^ $past(lcd_seg_o)) & $past(lcd_act & ~{8{floated}})) == 8'h00)
      && ((pin_oe_n & $past(lcd_act & ~{8{floated}})) == 8'h00))
    else $error("lcd segment not given priority");

  a_analog_block: assert property (
    (regs_q.analog_disable == 8'h00) [*2] |=> level == 8'h00)
    else $error("digital input open with analog enabled");

  // per-pin read views: plain port outputs return the latch, all others the pin
  a_output_read_latch: assert property (
    latch_rd |=> ((hrdata[7:0] ^ $past(regs_d.latch))
      & $past(regs_d.direction & port_mode)) == 8'h00)
    else $error("output pin read did not return latch");

  a_input_read_pin: assert property (
    latch_rd |=> ((hrdata[7:0] ^ $past(level)) & ~$past(regs_d.direction)) == 8'h00)
    else $error("input pin read did not return pin level");

  a_periph_read_pin: assert property (
    latch_rd |=> ((hrdata[7:0] ^ $past(level)) & $past(periph_oe)) == 8'h00)
    else $error("peripheral pin read did not return pin level");

  a_input_write_hold: assert property (
    latch_wr |=> (regs_q.latch == $past(hwdata[7:0]))
      ##1 ((~pin_oe_n & $past(in_mask)) == 8'h00))
    else $error("latch write drove an input pin");

  // standby without float must leave every pad exactly as it was
  a_standby_hold: assert property (
    $rose(standby_req) && !floated && $stable(regs_q) && $stable(periph_oe)
      && $stable(periph_o) && $stable(lcd_seg_o)
      |=> $stable(pin_oe_n) && $stable(pin_o))
    else $error("standby without float changed a pin");

  // three flops from pad to interrupt feed; skip the cycles just after reset
  a_irq_feed: assert property (
    !floated && $past(seen_q) |=> ext_irq_level == $past(pin_i, 3))
    else $error("pin level not fed to interrupt circuit");

  a_float_irq_open: assert property (
    floated && $past(seen_q) |=> (((ext_irq_level ^ $past(pin_i, 3)) & $past(ext_irq_en))
      | ((periph_in ^ $past(pin_i, 3)) & $past(ext_irq_en & regs_q.analog_disable)))
      == 8'h00)
    else $error("interrupt-enabled pin blocked in floated standby");

  c_floated_standby: cover property (floated ##1 floated);
  c_rmw_read: cover property (rmw_rd ##1 hready);
  c_lcd_drive: cover property (lcd_act != 8'h00 ##1 pin_oe_n != 8'hFF);
  c_write_then_read: cover property (latch_wr && latch_rd);
  c_periph_read: cover property (latch_rd && (periph_oe != 8'h00));

endmodule : port0_general_io

/* testbench/pad_model.sv */
// pad model: external pin levels seen by port 0
`timescale 1ns/100ps
module pad_model (
  input wire logic [7:0] pin_o, // port output levels
  input wire logic [7:0] pin_oe_n, // port output enables, low drives
  input wire logic [7:0] ext_en, // external driver active per pin
  input wire logic [7:0] ext_val, // external driver levels
  output logic [7:0] pin_i // resolved pad levels
);
  // ----------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------
  // a pin nobody drives shows the inverse of the port value, never a kind guess
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      if (!pin_oe_n[n]) begin
        pin_i[n] = pin_o[n];
      end else if (ext_en[n]) begin
        pin_i[n] = ext_val[n];
      end else begin
        pin_i[n] = ~pin_o[n];
      end
    end
  end
endmodule : pad_model

/* testbench/tb_top.sv */
// testbench for port 0: ahb-lite register access and pin scenarios
`timescale 1ns/100ps
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata, rd;
  logic standby_req = 1'b0;
  logic [7:0] periph_oe = 8'h00, periph_o = 8'h00, lcd_seg_o = 8'h00, ext_irq_en = 8'h00;
  logic [7:0] ext_en = 8'hFF, ext_val = 8'h3C, keep_oe_n, keep_o;
  logic [7:0] pin_i, pin_o, pin_oe_n, periph_in, ext_irq_level, analog_input_en;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;

  port0_general_io dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .standby_req(standby_req),
    .periph_oe(periph_oe), .periph_o(periph_o), .lcd_seg_o(lcd_seg_o),
    .ext_irq_en(ext_irq_en), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
    .periph_in(periph_in), .ext_irq_level(ext_irq_level), .analog_input_en(analog_input_en));

  pad_model pads (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_en(ext_en), .ext_val(ext_val),
    .pin_i(pin_i));

  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  always #2.5 hclk = ~hclk;

  // cut a hang short well above the expected run length
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one ahb-lite single transfer, launched at a rising edge by non-blocking assignment
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, rd, {24'h0, exp});
  endtask : rd_chk

  // let pin paths and the input synchroniser settle, stay just after an edge
  task automatic settle();
    repeat (5) @(posedge hclk);
    #1;
  endtask : settle

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    chk("oe_n reset", {24'h0, pin_oe_n}, 32'hFF);
    chk("analog en reset", {24'h0, analog_input_en}, 32'hFF);
    @(posedge hclk);
    rd_chk("direction reset", 8'h04, 8'h00);
    rd_chk("analog reset", 8'h08, 8'h00);
    rd_chk("blocked input", 8'h00, 8'h00);
    rd_chk("unmapped", 8'h20, 8'h00);
    $display("test reset done");
    // input mode: latch written, pins stay released
    wr(8'h00, 8'hA5);
    settle();
    chk("input oe_n", {24'h0, pin_oe_n}, 32'hFF);
    rd_chk("rmw latch", 8'h14, 8'hA5);
    wr(8'h08, 8'h0F);
    settle();
    chk("analog en", {24'h0, analog_input_en}, 32'hF0);
    rd_chk("gated pins", 8'h00, 8'h0C);
    wr(8'h08, 8'hFF);
    settle();
    rd_chk("pin levels", 8'h00, 8'h3C);
    $display("test input done");
    // output mode on the low nibble
    wr(8'h04, 8'h0F);
    settle();
    chk("out oe_n", {24'h0, pin_oe_n}, 32'hF0);
    chk("out level", {24'h0, pin_o & 8'h0F}, 32'h05);
    rd_chk("mixed read", 8'h00, 8'h35);
    wr(8'h00, 8'h5A);
    settle();
    chk("new level", {24'h0, pin_o & 8'h0F}, 32'h0A);
    $display("test output done");
    // peripheral overrides the port latch on pin 0
    @(posedge hclk);
    periph_oe <= 8'h01;
    periph_o <= 8'h01;
    settle();
    chk("periph drive", {31'h0, pin_o[0]}, 32'h1);
    rd_chk("periph pin", 8'h00, 8'h3B);
    rd_chk("periph rmw", 8'h14, 8'h5A);
    $display("test peripheral done");
    // lcd segment wins over peripheral and latch on pin 1
    wr(8'h04, 8'h0D);
    wr(8'h10, 8'hFF);
    rd_chk("seg bit0 fixed", 8'h10, 8'hFE);
    wr(8'h10, 8'h02);
    wr(8'h0C, 8'h01);
    periph_oe <= 8'h02;
    periph_o <= 8'h02;
    settle();
    chk("lcd priority", {31'h0, pin_o[1]}, 32'h0);
    chk("lcd drives", {31'h0, pin_oe_n[1]}, 32'h0);
    $display("test lcd done");
    // standby without float holds, with float releases
    @(posedge hclk);
    periph_oe <= 8'h00;
    settle();
    keep_oe_n = pin_oe_n;
    keep_o = pin_o;
    @(posedge hclk);
    standby_req <= 1'b1;
    ext_irq_en <= 8'h80;
    ext_val <= 8'hFF;
    settle();
    chk("standby hold", {24'h0, pin_oe_n}, {24'h0, keep_oe_n});
    chk("standby level", {24'h0, pin_o}, {24'h0, keep_o});
    wr(8'h0C, 8'h03);
    settle();
    chk("float oe_n", {24'h0, pin_oe_n}, 32'hFF);
    chk("float inputs", {24'h0, periph_in}, 32'h80);
    @(posedge hclk);
    standby_req <= 1'b0;
    ext_irq_en <= 8'h00;
    $display("test standby done");
    // analog use: irq level still follows the pins
    wr(8'h10, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h00);
    ext_val <= 8'hC3;
    settle();
    chk("irq level", {24'h0, ext_irq_level}, 32'hC3);
    chk("analog blocks", {24'h0, periph_in}, 32'h00);
    chk("analog path", {24'h0, analog_input_en}, 32'hFF);
    $display("test analog done");
    end_of_test();
  end
endmodule : tb_top
